// >>> design/usb_host_cmd_sts.v
// Command and status register pair of a host controller, with the
// microframe counter, interrupt gating and reset sequencing they steer.
// Assumes one clock, synchronous inputs and a single-cycle strobe bus.
//
// Function
// - Command register writes act immediately.
// - Soft reset resets core, keeps port state.
// - Frame list size resets 00b, sets entries.
// - Full reset bit holds one, self-clears.
// - Run/stop one runs schedule, zero stops.
// - Status flags clear on written one or full reset.
// - Status holds no per-transaction outcome.
// - Rollover flag sets on index wrap.
// - Port change flag sets on port events.
// - Enabled set flag raises the interrupt.
// - Index advances once each 125 us microframe while running.
`timescale 1ns/1ps
`include "usb_host_cmd_sts_defines.vh"

module usb_host_cmd_sts #(
    parameter MICROFRAME_CYCLES = `MICROFRAME_CYCLES,
    parameter FULL_RESET_CYCLES = `FULL_RESET_CYCLES
) (
    // Clock, reset and enable.
    input  wire        core_clk,
    input  wire        srst,
    input  wire        clkEn,
    // Register port.
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // Port status events from the port logic.
    input  wire        portBitRise,
    input  wire        ownershipHandoff,
    input  wire        remoteResumeFlag,
    // Controls, microframe index and status flags to the controller core.
    output reg         runStop,
    output reg  [1:0]  frameListSize,
    output reg         softControllerReset,
    output reg         controllerFullReset,
    output reg  [13:0] microframeIndex,
    output reg         frameListRollover,
    output reg         portChangeDetect,
    // Interrupt.
    output reg         irq
);

    // ------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------
    localparam FR_IDLE = 1'b0;         // No full reset running.
    localparam FR_BUSY = 1'b1;         // Full reset in progress.

    reg [31:0] cmd_q;                  // Command register.
    reg [31:0] cmd_d;
    reg [31:0] sts_q;                  // Sticky status flags.
    reg [31:0] sts_d;
    reg [31:0] ien_q;                  // Interrupt enables.
    reg [31:0] ien_d;
    reg [13:0] idx_q;                  // Microframe index.
    reg [13:0] idx_d;
    reg [15:0] tick_q;                 // Cycles within microframe.
    reg [15:0] tick_d;
    reg [4:0]  rcnt_q;                 // Full reset cycle counter.
    reg [4:0]  rcnt_d;
    reg        frState_q;              // Full reset state.
    reg        frState_d;
    reg        resumePrev_q;           // Resume flag last cycle.
    reg [31:0] rd_d;                   // Read data next value.
    reg        wrap;                   // Index wraps this cycle.
    reg        pcdEvt;                 // Port change event.
    reg        step;                   // Index advances this cycle.
    reg [31:0] clrMask;                // Flags cleared by software.
    reg [31:0] setMask;                // Flags set by hardware.

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Write decode for one register offset.
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        input       wr;
        begin
            hit = wr && (a == ofs);
        end
    endfunction

    // Highest index bit that still lies inside the frame list;
    // the reserved code falls back to the largest list.
    function [3:0] topBit;
        input [1:0] frame_list_size;
        begin
            case (frame_list_size)
                `FLS_512: topBit = 4'hb;
                `FLS_256: topBit = 4'ha;
                default:  topBit = 4'hc;
            endcase
        end
    endfunction

    // Mask of the index bits that count entries of the current list;
    // the index wraps once all of them are ones.
    function [13:0] wrapMask;
        input [1:0] frame_list_size;
        begin
            wrapMask = (14'h0002 << topBit(frame_list_size)) - 14'h0001;
        end
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Microframe timing and index wrap detection.
    // One step per microframe while running. A stop also zeroes the
    // sub-microframe counter, so a restart begins a full microframe.
    always @*
    begin
        step   = (tick_q == MICROFRAME_CYCLES - 1) &&
                 cmd_q[`CMD_RUN_STOP_BIT];
        tick_d = tick_q;
        idx_d  = idx_q;
        if (!cmd_q[`CMD_RUN_STOP_BIT])
        begin
            // Stopped: the index holds its value.
            tick_d = 16'h0000;
        end
        else if (step)
        begin
            tick_d = 16'h0000;
            idx_d  = idx_q + 14'h0001;
        end
        else
        begin
            tick_d = tick_q + 16'h0001;
        end
        // Wrap when every bit up to the top bit is one.
        wrap = step &&
               ((idx_q & wrapMask(cmd_q[3:2])) == wrapMask(cmd_q[3:2]));
    end

    // Command register and full reset sequencer.
    always @*
    begin
        cmd_d     = cmd_q;
        frState_d = frState_q;
        rcnt_d    = rcnt_q;
        if (hit(regAddr, `HOST_COMMAND_OFS, regWr))
        begin
            // Only defined fields are stored; the rest read zero.
            cmd_d = regWrData & 32'h0000_008f;
        end
        // The full reset owns the command register until it ends;
        // software sees bit 1 high the whole time and polls it.
        case (frState_q)
            FR_IDLE:
            begin
                if (cmd_d[`CMD_FULL_RST_BIT])
                begin
                    frState_d = FR_BUSY;
                    rcnt_d    = 5'h00;
                end
            end
            FR_BUSY:
            begin
                // Writes during the reset cannot end it early.
                cmd_d = 32'h0000_0002;
                if (rcnt_q == FULL_RESET_CYCLES - 1)
                begin
                    frState_d = FR_IDLE;
                    cmd_d     = `CMD_RESET_VAL;
                end
                else
                begin
                    rcnt_d = rcnt_q + 5'h01;
                end
            end
            default:
            begin
                frState_d = FR_IDLE;
            end
        endcase
    end

    // Status flags, enables and read data.
    always @*
    begin
        pcdEvt  = (portBitRise && !ownershipHandoff) ||
                  (remoteResumeFlag && !resumePrev_q);
        setMask = 32'h0000_0000;
        setMask[`STS_FLR_BIT] = wrap;
        setMask[`STS_PCD_BIT] = pcdEvt;
        clrMask = 32'h0000_0000;
        // Only the two defined flags can be cleared; ones written to
        // the reserved bits have no effect.
        if (hit(regAddr, `HOST_STATUS_OFS, regWr) ||
            hit(regAddr, `STATUS_CLEAR_OFS, regWr))
        begin
            clrMask = regWrData & 32'h0000_000c;
        end
        // A set in the same cycle as its clear wins.
        sts_d = (sts_q & ~clrMask) | setMask;
        ien_d = ien_q;
        if (hit(regAddr, `IRQ_ENABLE_OFS, regWr))
        begin
            ien_d = regWrData & 32'h0000_000c;
        end
        // A full reset wipes the flags and enables; events that arrive
        // during it are lost, which software must expect.
        if (frState_q == FR_BUSY)
        begin
            sts_d = `STS_RESET_VAL;
            ien_d = 32'h0000_0000;
        end
        // Read data is zero unless a read strobe is present, so the
        // registered port shows a value only in the cycle after it.
        rd_d = 32'h0000_0000;
        if (regRd)
        begin
            case (regAddr)
                `HOST_COMMAND_OFS: rd_d = cmd_q;
                `HOST_STATUS_OFS:  rd_d = sts_q;
                `IRQ_ENABLE_OFS:   rd_d = ien_q;
                `MICROFRAME_OFS:   rd_d = {18'h0, idx_q};
                default:           rd_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // All state is frozen while the clock enable is low.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            cmd_q        <= `CMD_RESET_VAL;
            sts_q        <= `STS_RESET_VAL;
            ien_q        <= 32'h0000_0000;
            idx_q        <= 14'h0000;
            tick_q       <= 16'h0000;
            rcnt_q       <= 5'h00;
            frState_q    <= FR_IDLE;
            resumePrev_q <= 1'b0;
            regRdData    <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            cmd_q        <= cmd_d;
            sts_q        <= sts_d;
            ien_q        <= ien_d;
            idx_q        <= (frState_q == FR_BUSY) ? 14'h0000 : idx_d;
            tick_q       <= (frState_q == FR_BUSY) ? 16'h0000 : tick_d;
            rcnt_q       <= rcnt_d;
            frState_q    <= frState_d;
            resumePrev_q <= remoteResumeFlag;
            regRdData    <= rd_d;
        end
    end

    // Outputs are registered copies of the next state, so the
    // core sees a written command on the edge that stores it.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            runStop             <= 1'b0;
            frameListSize       <= `FLS_1024;
            softControllerReset <= 1'b0;
            controllerFullReset <= 1'b0;
            microframeIndex     <= 14'h0000;
            frameListRollover   <= 1'b0;
            portChangeDetect    <= 1'b0;
            irq                 <= 1'b0;
        end
        else if (clkEn)
        begin
            runStop             <= cmd_d[`CMD_RUN_STOP_BIT];
            frameListSize       <= cmd_d[3:2];
            // Ports and ownership are untouched by this reset.
            // Nothing inside this bank is reset by it; the core is.
            softControllerReset <= cmd_d[`CMD_SOFT_RST_BIT];
            controllerFullReset <= cmd_d[`CMD_FULL_RST_BIT];
            microframeIndex     <= (frState_q == FR_BUSY) ?
                                   14'h0000 : idx_d;
            frameListRollover   <= sts_d[`STS_FLR_BIT];
            portChangeDetect    <= sts_d[`STS_PCD_BIT];
            // The interrupt is a level: it falls once software clears
            // the flag or its enable.
            irq                 <= |(sts_d & ien_d);
        end
    end

endmodule // usb_host_cmd_sts

// >>> design/usb_host_cmd_sts_defines.vh
// Offsets, field positions, reset values and timing counts for the
// host command and status register bank.
// Assumes byte addresses on an 8-bit register address port.
`ifndef USB_HOST_CMD_STS_DEFINES_VH
`define USB_HOST_CMD_STS_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HOST_COMMAND_OFS   8'h8c
`define HOST_STATUS_OFS    8'h90
`define IRQ_ENABLE_OFS     8'h94
`define MICROFRAME_OFS     8'h98
`define STATUS_CLEAR_OFS   8'he4

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define CMD_RUN_STOP_BIT   0
`define CMD_FULL_RST_BIT   1
`define CMD_FLS_LO_BIT     2
`define CMD_FLS_HI_BIT     3
`define CMD_SOFT_RST_BIT   7
`define CMD_RESET_VAL      32'h0000_0000

// ----------------------------------------------------------------
// Status and enable fields (same layout)
// ----------------------------------------------------------------
`define STS_PCD_BIT        2
`define STS_FLR_BIT        3
`define STS_RESET_VAL      32'h0000_0000

// ----------------------------------------------------------------
// Frame list size codes
// ----------------------------------------------------------------
`define FLS_1024           2'h0
`define FLS_512            2'h1
`define FLS_256            2'h2
`define FLS_RSVD           2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS      8000
`define MICROFRAME_US      125
`define MICROFRAME_CYCLES  ((`MICROFRAME_US * 1000000) / `CLK_PERIOD_PS)
`define FULL_RESET_CYCLES  16

`endif

// >>> test/usb_host_cmd_sts_checker.sv
// Concurrent checks on the ports of the host command and status bank.
// Assumes no strobe or port event arrives while clkEn is low.
`timescale 1ns/1ps
`include "usb_host_cmd_sts_defines.vh"

module usb_host_cmd_sts_checker (
    // Clock and reset.
    input wire        core_clk,
    input wire        srst,
    // Register port.
    input wire [7:0]  regAddr,
    input wire [31:0] regWrData,
    input wire        regWr,
    input wire        regRd,
    input wire [31:0] regRdData,
    // Port events.
    input wire        portBitRise,
    input wire        ownershipHandoff,
    input wire        remoteResumeFlag,
    // Core controls, flags and interrupt.
    input wire        runStop,
    input wire [1:0]  frameListSize,
    input wire        softControllerReset,
    input wire        controllerFullReset,
    input wire [13:0] microframeIndex,
    input wire        frameListRollover,
    input wire        portChangeDetect,
    input wire        irq
);
    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    // A command write; one with bit 1 set also starts a full reset that wipes flags.
    wire cmdWr = regWr && (regAddr == `HOST_COMMAND_OFS);
    // A write of one to the rollover flag through either clear path.
    wire clrRoll = regWr && regWrData[3] &&
        (regAddr == `HOST_STATUS_OFS || regAddr == `STATUS_CLEAR_OFS);

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    cmd_write_a: assert property (
        cmdWr && !controllerFullReset && !regWrData[1] |=>
        runStop == $past(regWrData[0]) &&
        frameListSize == $past(regWrData[3:2]) &&
        softControllerReset == $past(regWrData[7]))
        else $error("command write not applied");
    cmd_hold_a: assert property (
        !cmdWr && !controllerFullReset |=> $stable(runStop) &&
        $stable(frameListSize) && $stable(softControllerReset))
        else $error("command outputs moved without a write");
    full_reset_span_a: assert property (
        $rose(controllerFullReset) |->
        controllerFullReset [*8] ##1 controllerFullReset [*8] ##1
        !controllerFullReset)
        else $error("full reset span wrong");
    roll_sticky_a: assert property (
        frameListRollover && !clrRoll && !controllerFullReset |=>
        frameListRollover)
        else $error("rollover flag lost without a clear");
    port_set_a: assert property (
        portBitRise && !ownershipHandoff && !cmdWr &&
        !controllerFullReset |=> portChangeDetect)
        else $error("port event not flagged");
    resume_set_a: assert property (
        $rose(remoteResumeFlag) && !cmdWr && !controllerFullReset
        |=> portChangeDetect)
        else $error("resume event not flagged");
    irq_quiet_a: assert property (
        !frameListRollover && !portChangeDetect |-> !irq)
        else $error("interrupt without a flag");
    roll_point_a: assert property (
        $rose(frameListRollover) |-> microframeIndex[9:0] == 10'h000)
        else $error("rollover away from a wrap");
    index_step_a: assert property (
        $changed(microframeIndex) |->
        microframeIndex == $past(microframeIndex) + 14'h0001 ||
        microframeIndex == 14'h0000)
        else $error("index jumped");
endmodule // usb_host_cmd_sts_checker

bind usb_host_cmd_sts usb_host_cmd_sts_checker u_chk (.core_clk, .srst,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .portBitRise,
    .ownershipHandoff, .remoteResumeFlag, .runStop, .frameListSize,
    .softControllerReset, .controllerFullReset, .microframeIndex,
    .frameListRollover, .portChangeDetect, .irq);

// >>> test/usb_host_cmd_sts_tb.sv
// Self-checking bench for the host command and status bank.
// Assumes a short microframe parameter so a rollover fits the run.
`timescale 1ns/1ps
`include "usb_host_cmd_sts_defines.vh"

module usb_host_cmd_sts_tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    reg         core_clk = 1'b0;
    reg         srst = 1'b1;
    reg         clkEn = 1'b1;
    reg  [7:0]  regAddr = 8'h00;
    reg  [31:0] regWrData = 32'h0;
    reg         regWr = 1'b0;
    reg         regRd = 1'b0;
    reg         portBitRise = 1'b0;
    reg         ownershipHandoff = 1'b0;
    reg         remoteResumeFlag = 1'b0;
    wire [31:0] regRdData;
    wire        runStop;
    wire [1:0]  frameListSize;
    wire        softControllerReset;
    wire        controllerFullReset;
    wire [13:0] microframeIndex;
    wire        frameListRollover;
    wire        portChangeDetect;
    wire        irq;
    integer     mismatches = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    integer     n;
    reg  [13:0] held;

    // Four cycles a microframe keeps a 2048-step wrap near 8k cycles.
    usb_host_cmd_sts #(.MICROFRAME_CYCLES(4)) u_dut (.core_clk, .srst,
        .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .portBitRise, .ownershipHandoff, .remoteResumeFlag, .runStop,
        .frameListSize, .softControllerReset, .controllerFullReset,
        .microframeIndex, .frameListRollover, .portChangeDetect, .irq);

    // Free-running 8 ns clock.
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            regWr <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge core_clk);
            regWr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge core_clk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge core_clk);
            regRd <= 1'b0;
            #1;
            chk(regRdData, exp);
        end
    endtask
    // One port event pulse; the flag is looked at a cycle later.
    task pulse(input h);
        begin
            @(posedge core_clk);
            portBitRise <= 1'b1;
            ownershipHandoff <= h;
            @(posedge core_clk);
            portBitRise <= 1'b0;
            @(posedge core_clk);
            #1;
        end
    endtask
    task stop_test;
        begin
            if (mismatches == 0 && check_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_cmd;
        begin
            rd(`HOST_COMMAND_OFS, 32'h0);
            rd(`HOST_STATUS_OFS, 32'h0);
            rd(8'h40, 32'h0);
            for (n = 0; n < 4; n = n + 1)
            begin
                wr(`HOST_COMMAND_OFS, n << 2);
                chk(frameListSize, n);
            end
            wr(`HOST_COMMAND_OFS, 32'h89);
            chk({runStop, softControllerReset}, 2'h3);
            rd(`HOST_COMMAND_OFS, 32'h89);
            wr(`HOST_COMMAND_OFS, 32'h09);
            chk(softControllerReset, 1'b0);
            wr(`HOST_COMMAND_OFS, 32'h0);
            chk(runStop, 1'b0);
            rd(`HOST_COMMAND_OFS, 32'h0);
        end
    endtask
    // Full reset self-clears; a write while busy is dropped.
    task t_full;
        begin
            wr(`HOST_COMMAND_OFS, 32'h2);
            chk(controllerFullReset, 1'b1);
            wr(`HOST_COMMAND_OFS, 32'h1);
            repeat (8) @(posedge core_clk);
            #1;
            chk(controllerFullReset, 1'b1);
            n = 0;
            while (controllerFullReset === 1'b1 && n < 40)
            begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            chk(controllerFullReset, 1'b0);
            chk(runStop, 1'b0);
            // Ten cycles of the span passed before the polling loop.
            chk(n, `FULL_RESET_CYCLES - 10);
            rd(`HOST_COMMAND_OFS, 32'h0);
        end
    endtask
    task t_roll;
        begin
            wr(`IRQ_ENABLE_OFS, 32'h8);
            wr(`HOST_COMMAND_OFS, 32'h9);
            n = 0;
            while (frameListRollover !== 1'b1 && n < 10000)
            begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            chk(microframeIndex, 14'h0800);
            chk(irq, 1'b1);
            wr(`HOST_COMMAND_OFS, 32'h0);
            rd(`HOST_STATUS_OFS, 32'h8);
            wr(`HOST_STATUS_OFS, 32'h0);
            chk(frameListRollover, 1'b1);
            wr(`HOST_STATUS_OFS, 32'h8);
            chk({frameListRollover, irq}, 2'h0);
        end
    endtask
    task t_port;
        begin
            wr(`IRQ_ENABLE_OFS, 32'h4);
            pulse(1'b1);
            chk(portChangeDetect, 1'b0);
            pulse(1'b0);
            chk({portChangeDetect, irq}, 2'h3);
            wr(`STATUS_CLEAR_OFS, 32'h4);
            chk(portChangeDetect, 1'b0);
            @(posedge core_clk);
            remoteResumeFlag <= 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
            chk(portChangeDetect, 1'b1);
            wr(`IRQ_ENABLE_OFS, 32'h0);
            chk(irq, 1'b0);
            wr(`HOST_STATUS_OFS, 32'h4);
            chk(portChangeDetect, 1'b0);
        end
    endtask
    // A low clock enable freezes the running microframe counter.
    task t_freeze;
        begin
            wr(`HOST_COMMAND_OFS, 32'h1);
            held = microframeIndex;
            @(posedge core_clk);
            clkEn <= 1'b0;
            repeat (20) @(posedge core_clk);
            clkEn <= 1'b1;
            #1;
            chk(microframeIndex, held);
            repeat (3) @(posedge core_clk);
            #1;
            chk(microframeIndex, held + 14'h0001);
            wr(`HOST_COMMAND_OFS, 32'h0);
        end
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        t_cmd;
        t_full;
        t_roll;
        t_port;
        t_freeze;
        stop_test;
    end
endmodule // usb_host_cmd_sts_tb
